// ===== common/bsob_pkg.sv
package bsob_pkg;
  // Register widths
  localparam int unsigned IR_W = 8;
  localparam int unsigned BSR_W = 18;
  localparam int unsigned BCR_W = 2;
  localparam int unsigned CTL_W = 17;
  // Boundary cell positions: inputs, enables, outputs
  localparam int unsigned BSR_A_LSB = 0;
  localparam int unsigned BSR_OE1 = 8;
  localparam int unsigned BSR_OE2 = 9;
  localparam int unsigned BSR_Y_LSB = 10;
  // Test control bundle: {mode, enables, values}
  localparam int unsigned CTL_TM = 16;
  localparam int unsigned CTL_OE_LSB = 8;
  // Reset and capture values
  localparam logic [7:0] IR_RESET = 8'hff;
  localparam logic [7:0] IR_CAPTURE = 8'h81;
  localparam logic [1:0] BCR_RESET = 2'h2;
  // Instruction opcodes
  localparam logic [7:0] OP_EXTEST = 8'h00;
  localparam logic [7:0] OP_SAMPLE = 8'h02;
  localparam logic [7:0] OP_INTEST = 8'h03;
  localparam logic [7:0] OP_HIGHZ = 8'h06;
  localparam logic [7:0] OP_CLAMP = 8'h07;
  localparam logic [7:0] OP_RUNT = 8'h09;
  localparam logic [7:0] OP_SCANCTL = 8'h0a;
  localparam logic [7:0] OP_BYPASS = 8'hff;
  // Test operations held in the control register
  localparam logic [1:0] BC_TOGGLE = 2'h0;
  localparam logic [1:0] BC_PATGEN = 2'h1;
  localparam logic [1:0] BC_SIGNAT = 2'h2;
  localparam logic [1:0] BC_SELFTEST = 2'h3;
  // Cycles of high mode-select that reach reset
  localparam int unsigned TLR_MAX = 5;
  // Controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR,
    ST_EX2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR,
    ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
  } bsob_state_e;
endpackage

// ===== common/bsob_tap_if.sv
interface bsob_tap_if;
  logic tms; // Mode select level
  logic tlr; // Reset state
  logic rti; // Idle state
  logic cap_dr; // Data capture
  logic sh_dr; // Data shift
  logic upd_dr; // Data update
  logic cap_ir; // Instruction capture
  logic sh_ir; // Instruction shift
  logic upd_ir; // Instruction update
  modport ctrl (input tms, output tlr, rti, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
  modport core (output tms, input tlr, rti, cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir);
endinterface // bsob_tap_if

// ===== logic/bsob_tap.sv
module bsob_tap (
  input wire logic tck_i,
  input wire logic trst_n_i,
  bsob_tap_if.ctrl tap
);
  bsob_pkg::bsob_state_e state_reg; // Current state
  bsob_pkg::bsob_state_e state_next; // Next state

  // Next state from mode select only
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      bsob_pkg::ST_TLR: state_next = tap.tms ? bsob_pkg::ST_TLR : bsob_pkg::ST_RTI;
      bsob_pkg::ST_RTI: state_next = tap.tms ? bsob_pkg::ST_SEL_DR : bsob_pkg::ST_RTI;
      bsob_pkg::ST_SEL_DR: state_next = tap.tms ? bsob_pkg::ST_SEL_IR : bsob_pkg::ST_CAP_DR;
      bsob_pkg::ST_CAP_DR: state_next = tap.tms ? bsob_pkg::ST_EX1_DR : bsob_pkg::ST_SH_DR;
      bsob_pkg::ST_SH_DR: state_next = tap.tms ? bsob_pkg::ST_EX1_DR : bsob_pkg::ST_SH_DR;
      bsob_pkg::ST_EX1_DR: state_next = tap.tms ? bsob_pkg::ST_UPD_DR : bsob_pkg::ST_PAU_DR;
      bsob_pkg::ST_PAU_DR: state_next = tap.tms ? bsob_pkg::ST_EX2_DR : bsob_pkg::ST_PAU_DR;
      bsob_pkg::ST_EX2_DR: state_next = tap.tms ? bsob_pkg::ST_UPD_DR : bsob_pkg::ST_SH_DR;
      bsob_pkg::ST_UPD_DR: state_next = tap.tms ? bsob_pkg::ST_SEL_DR : bsob_pkg::ST_RTI;
      bsob_pkg::ST_SEL_IR: state_next = tap.tms ? bsob_pkg::ST_TLR : bsob_pkg::ST_CAP_IR;
      bsob_pkg::ST_CAP_IR: state_next = tap.tms ? bsob_pkg::ST_EX1_IR : bsob_pkg::ST_SH_IR;
      bsob_pkg::ST_SH_IR: state_next = tap.tms ? bsob_pkg::ST_EX1_IR : bsob_pkg::ST_SH_IR;
      bsob_pkg::ST_EX1_IR: state_next = tap.tms ? bsob_pkg::ST_UPD_IR : bsob_pkg::ST_PAU_IR;
      bsob_pkg::ST_PAU_IR: state_next = tap.tms ? bsob_pkg::ST_EX2_IR : bsob_pkg::ST_PAU_IR;
      bsob_pkg::ST_EX2_IR: state_next = tap.tms ? bsob_pkg::ST_UPD_IR : bsob_pkg::ST_SH_IR;
      bsob_pkg::ST_UPD_IR: state_next = tap.tms ? bsob_pkg::ST_SEL_DR : bsob_pkg::ST_RTI;
      default: state_next = bsob_pkg::ST_TLR;
    endcase
  end

  // State advances on the rising test clock only
  always_ff @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      state_reg <= bsob_pkg::ST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  // Decoded controls for the scan registers
  assign tap.tlr = (state_reg == bsob_pkg::ST_TLR);
  assign tap.rti = (state_reg == bsob_pkg::ST_RTI);
  assign tap.cap_dr = (state_reg == bsob_pkg::ST_CAP_DR);
  assign tap.sh_dr = (state_reg == bsob_pkg::ST_SH_DR);
  assign tap.upd_dr = (state_reg == bsob_pkg::ST_UPD_DR);
  assign tap.cap_ir = (state_reg == bsob_pkg::ST_CAP_IR);
  assign tap.sh_ir = (state_reg == bsob_pkg::ST_SH_IR);
  assign tap.upd_ir = (state_reg == bsob_pkg::ST_UPD_IR);

  // Five high mode-select samples
  sequence five_high_s;
    tap.tms [*5];
  endsequence

  chk_tlr_five_high: assert property (
    @(posedge tck_i) disable iff (!trst_n_i) five_high_s |=> tap.tlr)
    else $error("reset state not reached after five high samples");
endmodule // bsob_tap

// ===== logic/bsob_top.sv
// Summary of operation
// - Test mode: test logic owns every pin
// - Normal mode: scans leave buffers untouched
// - Sample pin snapshot without disturbing buffers
// - Enable high floats, low passes input
// - Sample on rising, update on falling
// - Serial data shifts into selected register
// - Serial out only while shifting, else floats
// - States follow mode select and clock
// - Double-high mode select resets test logic
// - Controller uses only clock, select and test reset
// - Eight-bit instruction register
// - Boundary, control and bypass data registers
// - Standard, clamp, highz, intest, toggle instructions
// - Input signature and output pattern generation
// - Self test exercises boundary cells
// - Test reset loads all-ones instruction
// - Test reset loads control value two
// - Instruction capture loads fixed status
// - Five high selects reach reset state
module bsob_top (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic TCK_I,
  input wire logic TMS_I,
  input wire logic TMS_HIGH_I,
  input wire logic TDI_I,
  output logic TDO_O,
  output logic TDO_OE_O,
  input wire logic [3:0] GROUP_ONE_DATA_INPUTS_I,
  input wire logic [3:0] GROUP_TWO_DATA_INPUTS_I,
  input wire logic GROUP_ONE_OUTPUT_ENABLE_N_I,
  input wire logic GROUP_TWO_OUTPUT_ENABLE_N_I,
  output logic [3:0] GROUP_ONE_DATA_OUTPUTS_O,
  output logic [3:0] GROUP_ONE_DATA_OUTPUTS_OE_O,
  output logic [3:0] GROUP_TWO_DATA_OUTPUTS_O,
  output logic [3:0] GROUP_TWO_DATA_OUTPUTS_OE_O
);
  // Test reset: system reset or double-high select
  logic trst_n;
  assign trst_n = ARST_N_I & ~TMS_HIGH_I;

  // Controller link
  bsob_tap_if tap ();
  assign tap.tms = TMS_I;

  // Controller instance
  bsob_tap u_tap (
    .tck_i(TCK_I),
    .trst_n_i(trst_n),
    .tap(tap)
  );

  // ---- System clock side: pin filter and buffers

  logic [9:0] pin_raw; // {oe2, oe1, a2, a1}
  logic [9:0] pin_s1; // First stage
  logic [9:0] pin_s2; // Second stage
  logic [9:0] pin_s3; // Third stage
  logic [9:0] pin_f_reg; // Agreed pin level
  assign pin_raw = {GROUP_TWO_OUTPUT_ENABLE_N_I, GROUP_ONE_OUTPUT_ENABLE_N_I,
                    GROUP_TWO_DATA_INPUTS_I, GROUP_ONE_DATA_INPUTS_I};

  // Three-stage pin synchroniser
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_s1 <= 10'h3ff;
      pin_s2 <= 10'h3ff;
      pin_s3 <= 10'h3ff;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // Accept a level once stages two and three agree
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      pin_f_reg <= 10'h3ff;
    end else begin
      pin_f_reg <= (pin_s2 & pin_s3) | (pin_f_reg & (pin_s2 | pin_s3));
    end
  end

  // Test control from the test clock side
  logic [bsob_pkg::CTL_W-1:0] ctl_s1; // First stage
  logic [bsob_pkg::CTL_W-1:0] ctl_s2; // Second stage
  logic [bsob_pkg::CTL_W-1:0] ctl_s3; // Third stage
  logic [bsob_pkg::CTL_W-1:0] ctl_ok_reg; // Agreed control word
  logic [bsob_pkg::CTL_W-1:0] ctl_reg; // Held on falling test edge

  // Three-stage crossing of quasi-static control
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl_s1 <= '0;
      ctl_s2 <= '0;
      ctl_s3 <= '0;
    end else begin
      ctl_s1 <= ctl_reg;
      ctl_s2 <= ctl_s1;
      ctl_s3 <= ctl_s2;
    end
  end

  // Take the word only when two samples agree
  // A sample torn by a change lasts one cycle only, as long as
  // the test clock period stays well above three system clocks
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctl_ok_reg <= '0;
    end else if (ctl_s2 == ctl_s3) begin
      ctl_ok_reg <= ctl_s3;
    end
  end

  logic [7:0] y_reg; // Output levels
  logic [7:0] yoe_reg; // Output drive enables

  // Buffer outputs: plain buffer or test control
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      y_reg <= 8'h00;
      yoe_reg <= 8'h00;
    end else if (ctl_ok_reg[bsob_pkg::CTL_TM]) begin
      // Test mode owns the pins
      y_reg <= ctl_ok_reg[7:0];
      yoe_reg <= ctl_ok_reg[bsob_pkg::CTL_OE_LSB +: 8];
    end else begin
      // Normal buffering, scans have no say
      y_reg <= pin_f_reg[7:0];
      yoe_reg <= {{4{~pin_f_reg[9]}}, {4{~pin_f_reg[8]}}};
    end
  end

  assign GROUP_ONE_DATA_OUTPUTS_O = y_reg[3:0];
  assign GROUP_TWO_DATA_OUTPUTS_O = y_reg[7:4];
  assign GROUP_ONE_DATA_OUTPUTS_OE_O = yoe_reg[3:0];
  assign GROUP_TWO_DATA_OUTPUTS_OE_O = yoe_reg[7:4];

  chk_buf_pass_one: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (!ctl_ok_reg[bsob_pkg::CTL_TM] && !pin_f_reg[8])
    |=> (yoe_reg[3:0] == 4'hf) && (y_reg[3:0] == $past(pin_f_reg[3:0])))
    else $error("group one does not follow its inputs");

  chk_buf_float_two: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    (!ctl_ok_reg[bsob_pkg::CTL_TM] && pin_f_reg[9]) |=> (yoe_reg[7:4] == 4'h0))
    else $error("group two drives while disabled");

  chk_ctl_agreed_take: assert property (
    @(posedge CLK_I) disable iff (!ARST_N_I)
    !$stable(ctl_ok_reg) |-> ($past(ctl_s2) == $past(ctl_s3)))
    else $error("test control taken from a torn sample");

  // ---- Test clock side

  logic [17:0] obs_s1; // First stage of pin snapshot
  logic [17:0] obs_s2; // Pin snapshot at test clock

  // Two-stage crossing of pin levels
  always_ff @(posedge TCK_I or negedge trst_n) begin
    if (!trst_n) begin
      obs_s1 <= '0;
      obs_s2 <= '0;
    end else begin
      obs_s1 <= {y_reg, pin_f_reg};
      obs_s2 <= obs_s1;
    end
  end

  logic [bsob_pkg::IR_W-1:0] ir_sh; // Instruction shift stage
  logic [bsob_pkg::IR_W-1:0] ir_reg; // Active instruction
  logic [bsob_pkg::BSR_W-1:0] bsr_sh; // Boundary shift stage
  logic [bsob_pkg::BSR_W-1:0] bsr_up; // Boundary update cells
  logic [bsob_pkg::BCR_W-1:0] bcr_sh; // Control shift stage
  logic [bsob_pkg::BCR_W-1:0] bcr_up; // Active test operation
  logic byp_reg; // Bypass cell

  // Register selection from the instruction
  logic sel_bsr;
  logic sel_bcr;
  logic test_mode;
  logic op_intest;
  assign sel_bsr = (ir_reg == bsob_pkg::OP_EXTEST) || (ir_reg == bsob_pkg::OP_SAMPLE)
                   || (ir_reg == bsob_pkg::OP_INTEST);
  assign sel_bcr = (ir_reg == bsob_pkg::OP_SCANCTL);
  assign op_intest = (ir_reg == bsob_pkg::OP_INTEST);
  assign test_mode = (ir_reg == bsob_pkg::OP_EXTEST) || op_intest
                     || (ir_reg == bsob_pkg::OP_HIGHZ) || (ir_reg == bsob_pkg::OP_CLAMP)
                     || (ir_reg == bsob_pkg::OP_RUNT);

  // Instruction capture and shift on rising edge
  always_ff @(posedge TCK_I or negedge trst_n) begin
    if (!trst_n) begin
      ir_sh <= bsob_pkg::IR_RESET;
    end else if (tap.cap_ir) begin
      ir_sh <= bsob_pkg::IR_CAPTURE;
    end else if (tap.sh_ir) begin
      ir_sh <= {TDI_I, ir_sh[bsob_pkg::IR_W-1:1]};
    end
  end

  // Data capture and shift on rising edge
  always_ff @(posedge TCK_I or negedge trst_n) begin
    if (!trst_n) begin
      bsr_sh <= '0;
      bcr_sh <= bsob_pkg::BCR_RESET;
      byp_reg <= 1'b0;
    end else if (tap.cap_dr) begin
      // Snapshot of the pins, buffers undisturbed
      if (sel_bsr) begin
        bsr_sh <= obs_s2;
      end
      if (sel_bcr) begin
        bcr_sh <= bcr_up;
      end
      byp_reg <= 1'b0;
    end else if (tap.sh_dr) begin
      // Only the selected register moves
      if (sel_bsr) begin
        bsr_sh <= {TDI_I, bsr_sh[bsob_pkg::BSR_W-1:1]};
      end else if (sel_bcr) begin
        bcr_sh <= {TDI_I, bcr_sh[1]};
      end else begin
        byp_reg <= TDI_I;
      end
    end
  end

  // Instruction update on falling edge
  always_ff @(negedge TCK_I or negedge trst_n) begin
    if (!trst_n) begin
      ir_reg <= bsob_pkg::IR_RESET;
    end else if (tap.tlr) begin
      ir_reg <= bsob_pkg::IR_RESET;
    end else if (tap.upd_ir) begin
      ir_reg <= ir_sh;
    end
  end

  // Test operation register update
  always_ff @(negedge TCK_I or negedge trst_n) begin
    if (!trst_n) begin
      bcr_up <= bsob_pkg::BCR_RESET;
    end else if (tap.tlr) begin
      bcr_up <= bsob_pkg::BCR_RESET;
    end else if (tap.upd_dr && sel_bcr) begin
      bcr_up <= bcr_sh;
    end
  end

  // Pattern step shared by signature and generator
  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    lfsr_step = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  // Boundary update cells and idle-state test operations
  always_ff @(negedge TCK_I or negedge trst_n) begin
    if (!trst_n) begin
      bsr_up <= '0;
    end else if (tap.upd_dr && sel_bsr) begin
      bsr_up <= bsr_sh;
    end else if (tap.rti && (ir_reg == bsob_pkg::OP_RUNT)) begin
      case (bcr_up)
        bsob_pkg::BC_SIGNAT: begin
          // Fold inputs into a signature
          bsr_up[7:0] <= lfsr_step(bsr_up[7:0]) ^ obs_s2[7:0];
        end
        bsob_pkg::BC_PATGEN: begin
          // Pseudo-random output patterns
          bsr_up[17:10] <= lfsr_step(bsr_up[17:10]);
        end
        bsob_pkg::BC_TOGGLE: begin
          // Sample inputs, toggle outputs
          bsr_up[7:0] <= obs_s2[7:0];
          bsr_up[17:10] <= ~bsr_up[17:10];
        end
        default: begin
          // Rotate all cells to exercise them
          bsr_up <= {bsr_up[0], bsr_up[bsob_pkg::BSR_W-1:1]};
        end
      endcase
    end
  end

  // Test control bundle toward the buffers
  always_ff @(negedge TCK_I or negedge trst_n) begin
    if (!trst_n) begin
      ctl_reg <= '0;
    end else if (ir_reg == bsob_pkg::OP_HIGHZ) begin
      ctl_reg <= {1'b1, 8'h00, bsr_up[17:10]};
    end else begin
      ctl_reg[bsob_pkg::CTL_TM] <= test_mode;
      ctl_reg[15:12] <= {4{~bsr_up[bsob_pkg::BSR_OE2]}};
      ctl_reg[11:8] <= {4{~bsr_up[bsob_pkg::BSR_OE1]}};
      ctl_reg[7:0] <= op_intest ? bsr_up[7:0] : bsr_up[17:10];
    end
  end

  // Serial output, driven only while shifting
  always_ff @(negedge TCK_I or negedge trst_n) begin
    if (!trst_n) begin
      TDO_O <= 1'b1;
      TDO_OE_O <= 1'b0;
    end else begin
      TDO_OE_O <= tap.sh_dr || tap.sh_ir;
      if (tap.sh_ir) begin
        TDO_O <= ir_sh[0];
      end else if (sel_bsr) begin
        TDO_O <= bsr_sh[0];
      end else if (sel_bcr) begin
        TDO_O <= bcr_sh[0];
      end else begin
        TDO_O <= byp_reg;
      end
    end
  end

  // A bypass shift step: shifting with neither boundary nor control selected
  sequence byp_shift_s;
    tap.sh_dr && !sel_bsr && !sel_bcr;
  endsequence

  chk_bypass_shift: assert property (
    @(posedge TCK_I) disable iff (!trst_n) byp_shift_s |=> (byp_reg == $past(TDI_I)))
    else $error("bypass cell did not take serial input");

  chk_ir_capture: assert property (
    @(posedge TCK_I) disable iff (!trst_n) tap.cap_ir |=> (ir_sh == 8'h81))
    else $error("instruction capture pattern wrong");

  chk_ir_reset_ones: assert property (
    @(posedge TCK_I) disable iff (!trst_n)
    (tap.tlr && $past(tap.tlr)) |-> (ir_reg == 8'hff))
    else $error("instruction not all ones in reset state");

  chk_bcr_reset_val: assert property (
    @(posedge TCK_I) disable iff (!trst_n)
    (tap.tlr && $past(tap.tlr)) |-> (bcr_up == 2'h2))
    else $error("test operation not signature after reset");

  chk_tdo_float: assert property (
    @(posedge TCK_I) disable iff (!trst_n)
    (!tap.sh_dr && !tap.sh_ir) |-> !TDO_OE_O)
    else $error("serial output driven outside shift");

  chk_normal_ctl: assert property (
    @(posedge TCK_I) disable iff (!trst_n)
    (tap.tlr [*2]) |-> !ctl_reg[bsob_pkg::CTL_TM])
    else $error("test mode held in reset state");
endmodule // bsob_top

// ===== bench/bsob_jtag_model.sv
module bsob_jtag_model (
  output logic tck_o,
  output logic tms_o,
  output logic tdi_o,
  input wire logic tdo_i,
  input wire logic tdo_oe_i
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released data output floats up to the pull-up level
  logic tdo_w;
  assign tdo_w = tdo_oe_i ? tdo_i : 1'b1;
  // Clock stands still low between frames
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // One test clock period, levels set after the falling edge
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #32 tck_o = 1'b1;
    tdo = tdo_w;
    #32 tck_o = 1'b0;
  endtask
  // Five high selects reach reset, then park in idle
  task automatic go_reset();
    logic d;
    repeat (5) step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
  endtask
  // Full scan from idle back to idle, LSB first
  task automatic scan(input logic ir, input int n, input logic [17:0] din,
                      output logic [17:0] dout, output logic oe_ok);
    logic d;
    dout = '0;
    step(1'b1, 1'b1, d);
    if (ir) begin
      step(1'b1, 1'b1, d);
    end
    step(1'b0, 1'b1, d);
    step(1'b0, 1'b1, d);
    // Let the falling-edge enable settle before reading it
    #2 oe_ok = tdo_oe_i;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], dout[i]);
    end
    #2 oe_ok = oe_ok & ~tdo_oe_i;
    step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
  endtask
endmodule // bsob_jtag_model

// ===== bench/tb_boundary_scan_octal_buffer.sv
module tb_boundary_scan_octal_buffer;
  timeunit 1ns;
  timeprecision 100ps;
  // Boundary preload: outputs a5, group one enabled, group two off
  localparam logic [17:0] PRE = {8'ha5, 1'b1, 1'b0, 8'h3c};
  logic clk, arst_n, tck, tms, tms_high, tdi, tdo, tdo_oe;
  logic [3:0] a1, a2, y1, y1_oe, y2, y2_oe;
  logic e1, e2, oe_ok;
  logic [17:0] dout;
  logic [31:0] rnd;
  logic [7:0] ops [4];
  int fails, compares, seed;
  // System clock
  initial clk = 1'b0;
  always #5 clk = ~clk;
  bsob_top dut (
    .CLK_I(clk),
    .ARST_N_I(arst_n),
    .TCK_I(tck),
    .TMS_I(tms),
    .TMS_HIGH_I(tms_high),
    .TDI_I(tdi),
    .TDO_O(tdo),
    .TDO_OE_O(tdo_oe),
    .GROUP_ONE_DATA_INPUTS_I(a1),
    .GROUP_TWO_DATA_INPUTS_I(a2),
    .GROUP_ONE_OUTPUT_ENABLE_N_I(e1),
    .GROUP_TWO_OUTPUT_ENABLE_N_I(e2),
    .GROUP_ONE_DATA_OUTPUTS_O(y1),
    .GROUP_ONE_DATA_OUTPUTS_OE_O(y1_oe),
    .GROUP_TWO_DATA_OUTPUTS_O(y2),
    .GROUP_TWO_DATA_OUTPUTS_OE_O(y2_oe)
  );
  bsob_jtag_model jtag (
    .tck_o(tck),
    .tms_o(tms),
    .tdi_o(tdi),
    .tdo_i(tdo),
    .tdo_oe_i(tdo_oe)
  );
  // Count and report one comparison
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic report_and_stop();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Pin model: {g2 enable, g2 data, g1 enable, g1 data} per instruction
  function automatic logic [15:0] expect_pins(input logic [7:0] op);
    logic [3:0] o1, o2;
    o1 = {4{~PRE[8]}};
    o2 = {4{~PRE[9]}};
    case (op)
      bsob_pkg::OP_EXTEST, bsob_pkg::OP_CLAMP: begin
        return {o2, PRE[17:14] & o2, o1, PRE[13:10] & o1};
      end
      bsob_pkg::OP_INTEST: begin
        // Outputs follow the input cells
        return {o2, PRE[7:4] & o2, o1, PRE[3:0] & o1};
      end
      bsob_pkg::OP_HIGHZ: return 16'h0;
      default: return {{4{~e2}}, a2 & {4{~e2}}, {4{~e1}}, a1 & {4{~e1}}};
    endcase
  endfunction
  // Compare pins, data masked by drive enable
  task automatic check_pins(input logic [7:0] op);
    check(32'({y2_oe, y2 & y2_oe, y1_oe, y1 & y1_oe}), 32'(expect_pins(op)));
  endtask
  // Drive buffer pins at a clock edge and let them settle
  task automatic set_pins(input logic [9:0] v);
    @(posedge clk);
    {e2, e1, a2, a1} <= v;
    repeat (8) @(posedge clk);
    #1;
  endtask
  // Instruction scan, checking capture status and output enable
  task automatic load_ir(input logic [7:0] op);
    jtag.scan(1'b1, 8, {10'h0, op}, dout, oe_ok);
    check(32'(dout[7:0]), 32'(bsob_pkg::IR_CAPTURE));
    check(32'(oe_ok), 32'h1);
    repeat (8) @(posedge clk);
    #1;
  endtask
  // Main sequence
  initial begin
    seed = 21;
    fails = 0;
    compares = 0;
    arst_n = 1'b0;
    tms_high = 1'b0;
    {e2, e1, a2, a1} = 10'h3ff;
    ops = '{bsob_pkg::OP_EXTEST, bsob_pkg::OP_HIGHZ, bsob_pkg::OP_CLAMP, 8'h55};
    fork
      begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
      end
      jtag.go_reset();
    join
    // Bypass selected by reset: one zero then shifted data
    jtag.scan(1'b0, 8, 18'h0b5, dout, oe_ok);
    check(32'(dout[7:0]), 32'h6a);
    check(32'(oe_ok), 32'h1);
    $display("test reset_bypass done");
    // Random buffering while instruction scans run
    fork
      repeat (3) load_ir(bsob_pkg::OP_BYPASS);
      repeat (12) begin
        rnd = $random(seed);
        set_pins(rnd[9:0]);
        check_pins(bsob_pkg::OP_BYPASS);
      end
    join
    $display("test normal_buffer done");
    // Snapshot of pins, preload of boundary cells
    set_pins(10'h2c5);
    load_ir(bsob_pkg::OP_SAMPLE);
    jtag.scan(1'b0, 18, PRE, dout, oe_ok);
    check(32'(dout[9:0]), 32'({e2, e1, a2, a1}));
    check_pins(bsob_pkg::OP_SAMPLE);
    $display("test sample done");
    // Test-mode instructions and an unknown opcode
    set_pins(10'h16a);
    foreach (ops[i]) begin
      load_ir(ops[i]);
      check_pins(ops[i]);
    end
    $display("test instructions done");
    // Double-high select resets test logic
    load_ir(bsob_pkg::OP_EXTEST);
    check_pins(bsob_pkg::OP_EXTEST);
    @(posedge clk);
    tms_high <= 1'b1;
    repeat (3) @(posedge clk);
    tms_high <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    check_pins(bsob_pkg::OP_BYPASS);
    check(32'(tdo_oe), 32'h0);
    jtag.go_reset();
    $display("test double_high done");
    // Five high selects from mid-shift reach reset
    load_ir(bsob_pkg::OP_EXTEST);
    jtag.step(1'b1, 1'b1, oe_ok);
    jtag.step(1'b0, 1'b1, oe_ok);
    jtag.step(1'b0, 1'b1, oe_ok);
    jtag.go_reset();
    repeat (8) @(posedge clk);
    #1;
    check_pins(bsob_pkg::OP_BYPASS);
    $display("test tms_reset done");
    // Control register reads its reset value, then takes toggle
    load_ir(bsob_pkg::OP_SCANCTL);
    jtag.scan(1'b0, 2, 18'(bsob_pkg::BC_TOGGLE), dout, oe_ok);
    check(32'(dout[1:0]), 32'(bsob_pkg::BCR_RESET));
    check(32'(oe_ok), 32'h1);
    // Internal test drives outputs from the input cells
    load_ir(bsob_pkg::OP_INTEST);
    jtag.scan(1'b0, 18, PRE, dout, oe_ok);
    repeat (8) @(posedge clk);
    #1;
    check(32'(dout[9:0]), 32'({e2, e1, a2, a1}));
    check_pins(bsob_pkg::OP_INTEST);
    // Idle run with toggle: outputs show the cells inverted once
    load_ir(bsob_pkg::OP_RUNT);
    jtag.step(1'b0, 1'b1, oe_ok);
    repeat (8) @(posedge clk);
    #1;
    check(32'({y2_oe, y1_oe, y2, y1}), 32'({8'h0f, ~PRE[17:10]}));
    $display("test control_ops done");
    report_and_stop();
  end
  // Watchdog well beyond the expected run time
  initial begin
    #400us;
    fails++;
    $display("watchdog expired at %0t", $time);
    report_and_stop();
  end
endmodule // tb_boundary_scan_octal_buffer
